// File: hw/dasr_defines.vh
// constants of the dual converter serial readout block
`ifndef DASR_DEFINES_VH
`define DASR_DEFINES_VH

// ---------------------------------------------------------------
// widths and depths
// ---------------------------------------------------------------
`define DASR_RES_W        13
`define DASR_FIFO_DEPTH   4
`define DASR_SIGN_MASK    13'h1000

// ---------------------------------------------------------------
// register byte offsets (word aligned)
// ---------------------------------------------------------------
`define DASR_OFS_CTRL     8'h00
`define DASR_OFS_STATUS   8'h04
`define DASR_OFS_RESULT   8'h08

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DASR_CTRL_EN_BIT     0
`define DASR_ST_MODE_LSB     0
`define DASR_ST_REF_BIT      2
`define DASR_ST_BUSY_BIT     3
`define DASR_ST_UNDER_BIT    4
`define DASR_ST_LEVEL_LSB    8
`define DASR_RES_CH2_LSB     16

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define DASR_CTRL_EN_RST     1'b1

// ---------------------------------------------------------------
// io mode strap codes
// ---------------------------------------------------------------
`define DASR_MODE_SE      2'b00
`define DASR_MODE_DIFF    2'b01
`define DASR_MODE_LPDIFF  2'b10

`endif

// File: hw/dasr_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module dasr_fifo #(
    parameter WIDTH = 26,
    parameter DEPTH = 4
) (
    input  wire                           clk_i,
    input  wire                           rst_n_i,
    input  wire                           in_valid_i,
    output wire                           in_ready_o,
    input  wire [WIDTH-1:0]               in_data_i,
    output wire                           out_valid_o,
    input  wire                           out_ready_i,
    output wire [WIDTH-1:0]               out_data_o,
    output wire [$clog2(DEPTH+1)-1:0]     level_o
);
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam CW = $clog2(DEPTH+1);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // storage words
    reg [AW-1:0]    wr_q;               // write pointer
    reg [AW-1:0]    rd_q;               // read pointer
    reg [CW-1:0]    cnt_q;              // words held

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    // honest full and empty come straight from the count
    assign in_ready_o  = (cnt_q != DEPTH[CW-1:0]);
    assign out_valid_o = (cnt_q != {CW{1'b0}});
    assign out_data_o  = mem_q[rd_q];
    assign level_o     = cnt_q;

    // ---------------------------------------------------------------
    // storage write, no reset needed on the data words
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // ---------------------------------------------------------------
    // pointers and count; wrap by compare so any depth works
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {CW{1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// File: hw/dasr_top.v
// dual channel converter serial readout: sar sequencer, pins, ahb regs
//
// Overview of operation
// - start falling edge holds sample, starts conversion
// - start input single-ended in every mode
// - each shift clock fall presents next bit
// - two channels, own outputs, shared shift clock
// - single-ended: result only on positive pin
// - differential: result on positive and negative pins
// - echo clock follows shift clock, matched to data
// - single-ended: echo only on positive pin
// - differential: echo on both pins
// - single-ended: negative echo pin high disables echo output
// - strap picks single, differential, low-power differential
// - reference enable low disables both buffers
// - result is 13-bit two's complement, sign msb
// - one approximation step per shift clock pulse
`timescale 1ns/100ps
`include "dasr_defines.vh"
module dasr_top #(
    parameter RES_W      = `DASR_RES_W,
    parameter FIFO_DEPTH = `DASR_FIFO_DEPTH
) (
    input  wire                       CLK_I,
    input  wire                       RST_N_I,
    // ahb-lite slave
    input  wire                       HSEL_I,
    input  wire [31:0]                HADDR_I,
    input  wire [1:0]                 HTRANS_I,
    input  wire                       HWRITE_I,
    input  wire [2:0]                 HSIZE_I,
    input  wire [31:0]                HWDATA_I,
    input  wire                       HREADY_I,
    output wire [31:0]                HRDATA_O,
    output wire                       HREADYOUT_O,
    output wire                       HRESP_O,
    // sampled analog values entering the hold stage
    input  wire                       SAMPLE_VALID_I,
    output wire                       SAMPLE_READY_O,
    input  wire [RES_W-1:0]           SAMPLE_CH1_I,
    input  wire [RES_W-1:0]           SAMPLE_CH2_I,
    // straps
    input  wire [1:0]                 IO_MODE_I,
    input  wire                       REF_BUFFER_ENABLE_I,
    output wire                       REF1_BUF_ON_O,
    output wire                       REF2_BUF_ON_O,
    output wire [1:0]                 IO_STD_O,
    // link pins
    input  wire                       CONVERT_START_N_I,
    input  wire                       SHIFT_CLK_P_I,
    input  wire                       SHIFT_CLK_N_I,
    output wire                       CH1_SERIAL_OUT_P_O,
    output wire                       CH1_SERIAL_OUT_N_O,
    output wire                       CH1_SERIAL_OUT_N_OE_O,
    output wire                       CH2_SERIAL_OUT_P_O,
    output wire                       CH2_SERIAL_OUT_N_O,
    output wire                       CH2_SERIAL_OUT_N_OE_O,
    output wire                       ECHO_CLOCK_OUT_P_O,
    output wire                       ECHO_CLOCK_OUT_P_OE_O,
    input  wire                       ECHO_CLOCK_OUT_N_I,
    output wire                       ECHO_CLOCK_OUT_N_O,
    output wire                       ECHO_CLOCK_OUT_N_OE_O
);
    localparam CW = $clog2(FIFO_DEPTH+1);
    localparam [RES_W-1:0] SIGN_MASK = `DASR_SIGN_MASK;
    localparam [3:0] LAST_IDX = RES_W - 1;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    reg  [1:0]         mode_q;        // strap caught during reset
    reg                ref_q;         // reference buffer enable
    reg                cnv_prev_q;    // start pin, last cycle
    reg                sck_prev_q;    // resolved shift clock, last cycle
    reg                echo_q;        // echo clock, aligned with data
    reg                echo_off_q;    // echo disabled by negative pin
    reg  [2*RES_W-1:0] held_q;        // held samples {ch2, ch1}
    reg  [2*RES_W-1:0] sar_q;         // approximation registers
    reg  [2*RES_W-1:0] result_q;      // last finished result
    reg  [1:0]         dout_q;        // serial bits {ch2, ch1}
    reg  [3:0]         idx_q;         // bit under decision
    reg                active_q;      // conversion in progress
    reg                under_q;       // start seen with fifo empty
    reg                en_q;          // conversions allowed
    reg                wr_pend_q;     // ahb write in data phase
    reg  [7:0]         wr_addr_q;     // its address
    reg  [31:0]        rdata_q;       // ahb read data
    reg  [31:0]        rd_mux;        // read selector
    reg                sck_lvl;       // resolved shift clock level

    wire               diff = (mode_q != `DASR_MODE_SE);
    wire [2*RES_W-1:0] fifo_data;
    wire               fifo_valid;
    wire [CW-1:0]      fifo_level;
    wire               cnv_fall;
    wire               sck_fall;
    wire               start;
    wire [1:0]         dec;
    wire [2*RES_W-1:0] sar_nx;
    wire [RES_W-1:0]   bit_mask;
    wire               acc;
    wire               under_clr;

    // ---------------------------------------------------------------
    // sample buffer: back-pressure reaches the sample source
    // ---------------------------------------------------------------
    dasr_fifo #(
        .WIDTH (2*RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_n_i     (RST_N_I),
        .in_valid_i  (SAMPLE_VALID_I),
        .in_ready_o  (SAMPLE_READY_O),
        .in_data_i   ({SAMPLE_CH2_I, SAMPLE_CH1_I}),
        .out_valid_o (fifo_valid),
        .out_ready_i (start),
        .out_data_o  (fifo_data),
        .level_o     (fifo_level)
    );

    // ---------------------------------------------------------------
    // straps: mode caught while reset is held, ref buffers live
    // ---------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            mode_q <= IO_MODE_I;
            ref_q  <= 1'b1;
        end else begin
            ref_q  <= REF_BUFFER_ENABLE_I;
        end
    end

    // both buffers share one enable; pull-up default is the reset value
    assign REF1_BUF_ON_O = ref_q;
    assign REF2_BUF_ON_O = ref_q;
    assign IO_STD_O      = mode_q;

    // ---------------------------------------------------------------
    // shift clock resolve: single pin, or pair with held level when
    // both legs agree (a glitch-free choice for a noisy crossing)
    // ---------------------------------------------------------------
    always @* begin
        if (!diff) begin
            sck_lvl = SHIFT_CLK_P_I;
        end else if (SHIFT_CLK_P_I != SHIFT_CLK_N_I) begin
            sck_lvl = SHIFT_CLK_P_I;
        end else begin
            sck_lvl = sck_prev_q;
        end
    end

    // start stays a plain single-ended input whatever the strap says
    assign cnv_fall = cnv_prev_q & ~CONVERT_START_N_I;
    assign sck_fall = sck_prev_q & ~sck_lvl;
    assign start    = cnv_fall & en_q;

    // ---------------------------------------------------------------
    // edge history and echo clock
    // ---------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cnv_prev_q <= 1'b1;
            sck_prev_q <= 1'b0;
            echo_q     <= 1'b0;
            echo_off_q <= 1'b0;
        end else begin
            cnv_prev_q <= CONVERT_START_N_I;
            sck_prev_q <= sck_lvl;
            // registered with the data so both move on one edge
            echo_q     <= sck_lvl;
            echo_off_q <= ~diff & ECHO_CLOCK_OUT_N_I;
        end
    end

    // ---------------------------------------------------------------
    // successive approximation, one decision per channel per step
    // ---------------------------------------------------------------
    assign bit_mask = {{(RES_W-1){1'b0}}, 1'b1} << idx_q;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            // offset binary view makes the compare unsigned
            wire [RES_W-1:0] ob   = held_q[g*RES_W +: RES_W] ^ SIGN_MASK;
            wire [RES_W-1:0] test = sar_q[g*RES_W +: RES_W] | bit_mask;
            wire             keep = (ob >= test);
            assign sar_nx[g*RES_W +: RES_W] =
                keep ? test : sar_q[g*RES_W +: RES_W];
            // sign decision is inverted back to two's complement
            assign dec[g] = keep ^ (idx_q == LAST_IDX);
        end
    endgenerate

    // ---------------------------------------------------------------
    // conversion sequencer; a new start beats a shift edge
    // ---------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            held_q   <= {(2*RES_W){1'b0}};
            sar_q    <= {(2*RES_W){1'b0}};
            result_q <= {(2*RES_W){1'b0}};
            dout_q   <= 2'b00;
            idx_q    <= 4'h0;
            active_q <= 1'b0;
        end else if (start) begin
            // hold both channels at once; empty fifo holds zero
            held_q   <= fifo_valid ? fifo_data : {(2*RES_W){1'b0}};
            sar_q    <= {(2*RES_W){1'b0}};
            idx_q    <= LAST_IDX;
            active_q <= 1'b1;
            dout_q   <= 2'b00;
        end else if (sck_fall & active_q) begin
            // both channels shift together, msb decided first
            dout_q <= dec;
            sar_q  <= sar_nx;
            if (idx_q == 4'h0) begin
                active_q <= 1'b0;
                result_q <= sar_nx ^ {SIGN_MASK, SIGN_MASK};
            end else begin
                idx_q <= idx_q - 4'h1;
            end
        end else if (sck_fall) begin
            // past the lsb the lines idle low
            dout_q <= 2'b00;
        end
    end

    // ---------------------------------------------------------------
    // pin drivers
    // ---------------------------------------------------------------
    assign CH1_SERIAL_OUT_P_O    = dout_q[0];
    assign CH1_SERIAL_OUT_N_O    = diff & ~dout_q[0];
    assign CH1_SERIAL_OUT_N_OE_O = diff;
    assign CH2_SERIAL_OUT_P_O    = dout_q[1];
    assign CH2_SERIAL_OUT_N_O    = diff & ~dout_q[1];
    assign CH2_SERIAL_OUT_N_OE_O = diff;
    // negative echo leg turns input in single-ended mode
    assign ECHO_CLOCK_OUT_P_O    = echo_q & ~echo_off_q;
    assign ECHO_CLOCK_OUT_P_OE_O = ~echo_off_q;
    assign ECHO_CLOCK_OUT_N_O    = diff & ~echo_q;
    assign ECHO_CLOCK_OUT_N_OE_O = diff;

    // ---------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ---------------------------------------------------------------
    assign acc         = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign HRDATA_O    = rdata_q;
    assign under_clr   = wr_pend_q & (wr_addr_q == `DASR_OFS_STATUS)
                       & HWDATA_I[`DASR_ST_UNDER_BIT];

    // read selector; unmapped words read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        case (HADDR_I[7:0])
            `DASR_OFS_CTRL: begin
                rd_mux[`DASR_CTRL_EN_BIT] = en_q;
            end
            `DASR_OFS_STATUS: begin
                rd_mux[`DASR_ST_MODE_LSB +: 2]   = mode_q;
                rd_mux[`DASR_ST_REF_BIT]         = ref_q;
                rd_mux[`DASR_ST_BUSY_BIT]        = active_q;
                rd_mux[`DASR_ST_UNDER_BIT]       = under_q;
                rd_mux[`DASR_ST_LEVEL_LSB +: CW] = fifo_level;
            end
            `DASR_OFS_RESULT: begin
                rd_mux[RES_W-1:0] = result_q[RES_W-1:0];
                rd_mux[`DASR_RES_CH2_LSB +: RES_W] = result_q[2*RES_W-1:RES_W];
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // address phase capture, data phase write
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            en_q      <= `DASR_CTRL_EN_RST;
        end else begin
            wr_pend_q <= acc & HWRITE_I;
            wr_addr_q <= HADDR_I[7:0];
            if (acc & ~HWRITE_I) begin
                rdata_q <= rd_mux;
            end
            if (wr_pend_q & (wr_addr_q == `DASR_OFS_CTRL)) begin
                en_q <= HWDATA_I[`DASR_CTRL_EN_BIT];
            end
        end
    end

    // underrun flag: set wins over a write-one clear
    always @(posedge CLK_I) begin
        if (!RST_N_I) begin
            under_q <= 1'b0;
        end else if (start & ~fifo_valid) begin
            under_q <= 1'b1;
        end else if (under_clr) begin
            under_q <= 1'b0;
        end
    end
endmodule

// File: sim/dasr_host_model.sv
// host side model: drives start and shift clock, latches both serial results
`timescale 1ns/100ps
module dasr_host_model (
    input  wire clk_i,
    input  wire diff_i,
    input  wire ch1_i,
    input  wire ch2_i,
    input  wire echo_i,
    output reg  start_n_o,
    output reg  sck_p_o,
    output wire sck_n_o
);
    reg        tgl_q;  // restless level for the unconnected negative pin
    reg        s1_q;   // shift level the device saw one edge back
    reg        s2_q;   // shift level the device saw two edges back
    reg        e1_q;   // echo level one edge back
    reg [12:0] w1;     // channel one word, msb first
    reg [12:0] w2;     // channel two word, msb first
    reg [4:0]  ne;     // echo falls seen in this frame
    initial begin
        {start_n_o, sck_p_o, tgl_q, s1_q, s2_q, e1_q, w1, w2, ne} = {2'h2, 4'h0, 31'h0};
    end
    // complement in differential mode; single-ended leaves it unconnected
    assign sck_n_o = diff_i ? ~sck_p_o : tgl_q;
    // latch with our own shift clock, one edge after the device saw it fall
    always @(posedge clk_i) begin
        tgl_q <= ~tgl_q;
        s1_q <= sck_p_o;
        s2_q <= s1_q;
        e1_q <= echo_i;
        if (s2_q && !s1_q) begin
            w1 <= {w1[11:0], ch1_i};
            w2 <= {w2[11:0], ch2_i};
        end
        // count restarts while start is idle high between frames
        if (start_n_o) begin
            ne <= 5'h0;
        end else if (e1_q && !echo_i) begin
            ne <= ne + 5'h1;
        end
    end
    // one frame: start fall on a clock edge, quiet time, 13 shift periods
    task frame(input int hi, input int lo);
        begin
            start_n_o <= 1'b0;
            repeat (2) @(posedge clk_i);
            repeat (13) begin
                sck_p_o <= 1'b1;
                repeat (hi) @(posedge clk_i);
                sck_p_o <= 1'b0;
                repeat (lo) @(posedge clk_i);
            end
            repeat (3) @(posedge clk_i);
            start_n_o <= 1'b1;
            @(posedge clk_i);
        end
    endtask
endmodule

// File: sim/dasr_top_asserts.sv
// concurrent checks on the strap, reference buffer and serial readout pins of the converter block
`timescale 1ns/100ps
`include "dasr_defines.vh"
module dasr_top_asserts (
    input wire       CLK_I,
    input wire       RST_N_I,
    input wire [1:0] IO_STD_O,
    input wire       REF_BUFFER_ENABLE_I,
    input wire       REF1_BUF_ON_O,
    input wire       REF2_BUF_ON_O,
    input wire       SHIFT_CLK_P_I,
    input wire       CH1_SERIAL_OUT_P_O,
    input wire       CH1_SERIAL_OUT_N_O,
    input wire       CH1_SERIAL_OUT_N_OE_O,
    input wire       CH2_SERIAL_OUT_P_O,
    input wire       CH2_SERIAL_OUT_N_O,
    input wire       CH2_SERIAL_OUT_N_OE_O,
    input wire       ECHO_CLOCK_OUT_P_O,
    input wire       ECHO_CLOCK_OUT_P_OE_O,
    input wire       ECHO_CLOCK_OUT_N_I,
    input wire       ECHO_CLOCK_OUT_N_O,
    input wire       ECHO_CLOCK_OUT_N_OE_O
);
    // ----------
    // one domain; nothing is judged while reset is held
    // ----------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    wire se = (IO_STD_O == `DASR_MODE_SE); // single-ended signalling
    wire ep = ECHO_CLOCK_OUT_P_O;          // short alias for the echo pin
    property p_ref_copy;
        REF1_BUF_ON_O == $past(REF_BUFFER_ENABLE_I) && REF2_BUF_ON_O == REF1_BUF_ON_O;
    endproperty
    a_ref_copy: assert property (p_ref_copy) else $error("ref buffers off their enable");
    property p_mode_hold;
        $stable(IO_STD_O);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("strap mode moved");
    property p_se_unused;
        se |-> !CH1_SERIAL_OUT_N_OE_O && !CH2_SERIAL_OUT_N_OE_O && !ECHO_CLOCK_OUT_N_OE_O;
    endproperty
    a_se_unused: assert property (p_se_unused) else $error("negative pin driven");
    property p_diff_data;
        !se |-> CH1_SERIAL_OUT_N_OE_O && CH1_SERIAL_OUT_N_O == !CH1_SERIAL_OUT_P_O
            && CH2_SERIAL_OUT_N_OE_O && CH2_SERIAL_OUT_N_O == !CH2_SERIAL_OUT_P_O;
    endproperty
    a_diff_data: assert property (p_diff_data) else $error("data pair broken");
    property p_diff_echo;
        !se |-> ECHO_CLOCK_OUT_P_OE_O && ECHO_CLOCK_OUT_N_OE_O && ECHO_CLOCK_OUT_N_O == !ep;
    endproperty
    a_diff_echo: assert property (p_diff_echo) else $error("echo pair broken");
    property p_echo_follow;
        ECHO_CLOCK_OUT_P_OE_O |-> ep == $past(SHIFT_CLK_P_I);
    endproperty
    a_echo_follow: assert property (p_echo_follow) else $error("echo lost shift");
    property p_echo_off;
        se && ECHO_CLOCK_OUT_N_I |=> !ECHO_CLOCK_OUT_P_OE_O && !ep;
    endproperty
    a_echo_off: assert property (p_echo_off) else $error("echo not disabled");
    // a one bit may only appear on an echo fall, on both channels alike
    property p_bit_on_fall;
        ECHO_CLOCK_OUT_P_OE_O && ($rose(CH1_SERIAL_OUT_P_O) || $rose(CH2_SERIAL_OUT_P_O))
            |-> $fell(ep);
    endproperty
    a_bit_on_fall: assert property (p_bit_on_fall) else $error("bit off fall");
endmodule
// every checker port carries the name of a port of the block
bind dasr_top dasr_top_asserts chk_u (.*);

// File: sim/tb.sv
// self-checking bench for the dual converter serial readout block
`timescale 1ns/100ps
module tb;
    reg         clk, rst_n, hsel, hwrite, s_valid, ref_en, diff, echo_tie;
    reg  [1:0]  htrans, io_mode;
    reg  [31:0] haddr, hwdata, rd;
    reg  [12:0] s_ch1, s_ch2;
    reg  [12:0] va [0:3], vb [0:3];
    integer     i, cyc, fails, n_checks;
    wire [31:0] hrdata;
    wire [1:0]  io_std;
    wire        hready, hresp, s_ready, ref1, ref2, c1p, c2p, ep, en_o, ene, start_n, sck_p, sck_n;
    // negative echo pin: the device when it drives, else our tie
    wire        echo_n = ene ? en_o : echo_tie;
    dasr_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .SAMPLE_VALID_I(s_valid), .SAMPLE_READY_O(s_ready), .SAMPLE_CH1_I(s_ch1),
        .SAMPLE_CH2_I(s_ch2), .IO_MODE_I(io_mode), .REF_BUFFER_ENABLE_I(ref_en),
        .REF1_BUF_ON_O(ref1), .REF2_BUF_ON_O(ref2), .IO_STD_O(io_std),
        .CONVERT_START_N_I(start_n), .SHIFT_CLK_P_I(sck_p), .SHIFT_CLK_N_I(sck_n),
        .CH1_SERIAL_OUT_P_O(c1p), .CH1_SERIAL_OUT_N_O(), .CH1_SERIAL_OUT_N_OE_O(),
        .CH2_SERIAL_OUT_P_O(c2p), .CH2_SERIAL_OUT_N_O(), .CH2_SERIAL_OUT_N_OE_O(),
        .ECHO_CLOCK_OUT_P_O(ep), .ECHO_CLOCK_OUT_P_OE_O(), .ECHO_CLOCK_OUT_N_I(echo_n),
        .ECHO_CLOCK_OUT_N_O(en_o), .ECHO_CLOCK_OUT_N_OE_O(ene));
    dasr_host_model host_u (.clk_i(clk), .diff_i(diff), .ch1_i(c1p), .ch2_i(c2p),
        .echo_i(ep), .start_n_o(start_n), .sck_p_o(sck_p), .sck_n_o(sck_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------
    // shared tasks
    // ----------
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("BAD %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // single ahb transfer: hold address phase, then data phase, until ready
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= a;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    task rdc(input string nm, input [31:0] a, input [31:0] exp);
        begin
            bus(1'b0, a, 32'h0000_0000);
            chk(nm, rd, exp);
            chk("okay", hresp, 1'b0);
        end
    endtask
    // an idle edge first, so valid never gets two values in one step
    task push(input [12:0] a, input [12:0] b);
        begin
            @(posedge clk);
            s_valid <= 1'b1;
            s_ch1 <= a;
            s_ch2 <= b;
            @(posedge clk);
            while (s_ready !== 1'b1) @(posedge clk);
            s_valid <= 1'b0;
        end
    endtask
    task conv(input [12:0] a, input [12:0] b, input [4:0] n, input [31:0] hi);
        begin
            host_u.frame(hi, 1);
            chk("ch1 word", host_u.w1, a);
            chk("ch2 word", host_u.w2, b);
            chk("echo falls", host_u.ne, n);
        end
    endtask
    task rst_dut(input [1:0] m, input t);
        begin
            rst_n <= 1'b0;
            io_mode <= m;
            diff <= (m != 2'h0);
            echo_tie <= t;
            repeat (3) @(posedge clk);
            rst_n <= 1'b1;
            @(posedge clk);
        end
    endtask
    // ----------
    // scenarios
    // ----------
    task t_regs;
        begin
            rdc("ctrl reset", 8'h00, 8'h01);
            rdc("status reset", 8'h04, 8'h04);
            bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
            rdc("unmapped", 8'h0C, 8'h00);
            ref_en <= 1'b0;
            repeat (2) @(posedge clk);
            chk("ref off", {ref1, ref2}, 2'h0);
            rdc("status ref off", 8'h04, 8'h00);
            ref_en <= 1'b1;
            repeat (2) @(posedge clk);
            chk("ref on", {ref1, ref2}, 2'h3);
        end
    endtask
    // fill until refused, then drain with slower and slower shift clocks
    task t_fifo;
        begin
            for (i = 0; i < 4; i = i + 1) push(va[i], vb[i]);
            @(posedge clk);
            s_valid <= 1'b1;
            repeat (3) @(posedge clk);
            chk("ready when full", s_ready, 1'b0);
            s_valid <= 1'b0;
            rdc("level full", 8'h04, 12'h404);
            for (i = 0; i < 4; i = i + 1) begin
                conv(va[i], vb[i], 5'hD, i + 1);
                rdc("result", 8'h08, {3'h0, vb[i], 3'h0, va[i]});
            end
            conv(13'h0, 13'h0, 5'hD, 1);
            rdc("underrun", 8'h04, 8'h14);
            bus(1'b1, 8'h04, 8'h10);
            rdc("underrun cleared", 8'h04, 8'h04);
        end
    endtask
    // start edges are ignored while conversions are switched off
    task t_disable;
        begin
            bus(1'b1, 8'h00, 8'h00);
            push(13'h0155, 13'h1EAA);
            conv(13'h0, 13'h0, 5'hD, 1);
            rdc("not popped", 8'h04, 12'h104);
            bus(1'b1, 8'h00, 8'h01);
            conv(13'h0155, 13'h1EAA, 5'hD, 2);
        end
    endtask
    task t_echo_off;
        begin
            rst_dut(2'h0, 1'b1);
            push(13'h0F0F, 13'h10F0);
            conv(13'h0F0F, 13'h10F0, 5'h0, 1);
            chk("echo idle", ep, 1'b0);
        end
    endtask
    task t_modes;
        begin
            for (i = 1; i < 3; i = i + 1) begin
                rst_dut(i[1:0], 1'b0);
                chk("strap", io_std, i[1:0]);
                rdc("status mode", 8'h04, 8'h04 | i);
                push(va[i], vb[i]);
                conv(va[i], vb[i], 5'hD, 2);
            end
        end
    endtask
    // ----------
    // main sequence and hang guard
    // ----------
    initial begin
        {rst_n, hsel, hwrite, s_valid, diff, echo_tie, htrans, io_mode} = 10'h0;
        {haddr, hwdata, s_ch1, s_ch2} = 90'h0;
        ref_en = 1'b1;
        {fails, n_checks, cyc} = 96'h0;
        va = '{13'h1000, 13'h0FFF, 13'h1FFF, 13'h0001};
        vb = '{13'h0AAA, 13'h1555, 13'h0000, 13'h1234};
        rst_dut(2'h0, 1'b0);
        t_regs;
        t_fifo;
        t_disable;
        t_echo_off;
        t_modes;
        test_done;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails = fails + 1;
            test_done;
        end
    end
endmodule
